// *** core/sip_pkg.sv ***
// package: constants and carrier types of the sensor interrupt block
package sip_pkg;
    localparam int unsigned ADR_W        = 9;
    localparam int unsigned DAT_W        = 32;
    localparam int unsigned SEL_W        = 4;
    localparam int unsigned IDX_W        = 7;
    localparam logic [6:0]  IDX_SLOT4_CTRL = 7'h34;
    localparam logic [6:0]  IDX_AUX_STAT   = 7'h36;
    localparam logic [6:0]  IDX_PIN_CFG    = 7'h37;
    localparam logic [6:0]  IDX_IRQ_EN     = 7'h38;
    localparam logic [6:0]  IDX_IRQ_STAT   = 7'h3A;
    localparam logic [6:0]  IDX_USER_CTRL  = 7'h6A;
    localparam int unsigned B_PASS       = 7;
    localparam int unsigned B_S4_DONE    = 6;
    localparam int unsigned B_ARB_LOST   = 5;
    localparam int unsigned B_NACK_LO    = 0;
    localparam int unsigned NACK_N       = 5;
    localparam int unsigned B_ACT_LOW    = 7;
    localparam int unsigned B_OPEN_DRAIN = 6;
    localparam int unsigned B_LATCH      = 5;
    localparam int unsigned B_ANY_RD_CLR = 4;
    localparam int unsigned B_FS_POL     = 3;
    localparam int unsigned B_FS_EN      = 2;
    localparam int unsigned B_BYPASS     = 1;
    localparam int unsigned B_OVF        = 4;
    localparam int unsigned B_MST        = 3;
    localparam int unsigned B_DRDY       = 0;
    localparam int unsigned B_S4_GATE    = 6;
    localparam int unsigned B_MST_ON     = 5;
    localparam logic [7:0]  PIN_CFG_MASK = 8'hFE;
    localparam logic [7:0]  IRQ_EN_MASK  = 8'h19;
    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam int unsigned PULSE_US     = 50;
    localparam int unsigned CLK_MHZ      = 125;
    localparam int unsigned PULSE_CYC    = PULSE_US * CLK_MHZ;
    localparam int unsigned CNT_W        = 16;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [SEL_W-1:0] sel;
        logic [DAT_W-1:0] dat;
    } sip_wb_req_t;

    typedef struct packed {
        logic             ack;
        logic [DAT_W-1:0] dat;
    } sip_wb_rsp_t;

    typedef struct packed {
        logic              slot4_done;
        logic              arb_lost;
        logic [NACK_N-1:0] nack;
    } sip_aux_evt_t;

    typedef enum logic [2:0] {
        PIN_IDLE  = 3'h1,
        PIN_PULSE = 3'h2,
        PIN_HOLD  = 3'h4
    } sip_pin_st_t;

    typedef struct packed {
        sip_pin_st_t      st;
        logic [CNT_W-1:0] cnt;
        logic             req_q;
        logic             active;
        logic             pin;
        logic             oe;
    } sip_pin_state_t;

    typedef struct packed {
        logic       ack;
        logic [7:0] rdat;
        logic [7:0] aux_stat;
        logic [7:0] irq_stat;
        logic [7:0] pin_cfg;
        logic [7:0] irq_en;
        logic       s4_gate;
        logic       mst_on;
        logic       fs_q;
        logic       bypass;
    } sip_core_state_t;
endpackage

// *** core/sip_pin_drive.sv ***
// interrupt pin driver: pulse or latch, polarity, push-pull or open drain
`timescale 1ns/10ps
module sip_pin_drive #(
    parameter int unsigned PULSE_CYC = sip_pkg::PULSE_CYC
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic req_i,
    input  wire logic act_low_i,
    input  wire logic open_drain_i,
    input  wire logic latch_i,
    output logic      pin_o,
    output logic      pin_oe_o,
    output logic      active_o
);
    sip_pkg::sip_pin_state_t s_reg;
    sip_pkg::sip_pin_state_t s_next;

    always_comb begin
        s_next       = s_reg;
        s_next.req_q = req_i;
        case (s_reg.st)
            sip_pkg::PIN_IDLE: begin
                if (latch_i && req_i) begin
                    s_next.st = sip_pkg::PIN_HOLD;
                end else if (!latch_i && req_i && !s_reg.req_q) begin
                    s_next.st  = sip_pkg::PIN_PULSE;
                    s_next.cnt = sip_pkg::CNT_W'(PULSE_CYC - 1);
                end
            end
            sip_pkg::PIN_PULSE: begin
                if (latch_i) begin
                    s_next.st = req_i ? sip_pkg::PIN_HOLD : sip_pkg::PIN_IDLE;
                end else if (s_reg.cnt == '0) begin
                    s_next.st = sip_pkg::PIN_IDLE;
                end else begin
                    s_next.cnt = s_reg.cnt - 1'b1;
                end
            end
            sip_pkg::PIN_HOLD: begin
                if (!req_i || !latch_i) begin
                    s_next.st = sip_pkg::PIN_IDLE;
                end
            end
            default: begin
                s_next.st = sip_pkg::PIN_IDLE;
            end
        endcase
        s_next.active = (s_next.st != sip_pkg::PIN_IDLE);
        s_next.pin    = s_next.active ^ act_low_i;
        s_next.oe     = open_drain_i ? s_next.active : 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_reg <= '{st: sip_pkg::PIN_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pin_o    = s_reg.pin;
    assign pin_oe_o = s_reg.oe;
    assign active_o = s_reg.active;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_pulse_start: assert property (
        $rose(s_reg.st == sip_pkg::PIN_PULSE) |-> s_reg.cnt == PULSE_CYC - 1
    ) else $error("pulse does not start at full length");
    a_pulse_end: assert property (
        s_reg.st == sip_pkg::PIN_PULSE && s_reg.cnt == '0 && !latch_i |=> !active_o
    ) else $error("pulse outlasts its length");
    a_pin_level: assert property (
        pin_o == (active_o ^ $past(act_low_i))
    ) else $error("pin level ignores polarity");
    a_od_release: assert property (
        $past(open_drain_i) && !active_o |-> !pin_oe_o
    ) else $error("open drain pin driven while inactive");
    a_latch_hold: assert property (
        latch_i && req_i && active_o |=> active_o
    ) else $error("latched interrupt dropped while pending");
    c_pulse: cover property (s_reg.st == sip_pkg::PIN_PULSE && s_reg.cnt == '0);
    c_hold: cover property (s_reg.st == sip_pkg::PIN_HOLD && open_drain_i);
endmodule

// *** core/sip_irq_core.sv ***
// interrupt status, enables and pin configuration with wishbone slave
//
// Behaviour
// - reading aux status clears all its flags
// - pass-through flag mirrors gated frame-sync event
// - slot-4 done sets flag, gated twice
// - arbitration loss sets flag and aux interrupt
// - per-slot not-acknowledge sets its own flag
// - polarity bit selects active high or low
// - open drain drives only the active level
// - pulse of 50 us or latched level
// - clear on status read or any read
// - frame-sync input polarity is selectable
// - frame-sync edge sets flag only when enabled
// - bypass only when enabled and master off
// - each source gated by its enable bit
// - any aux source raises combined aux interrupt, slot-4 done only with its gate set
// - data ready fires per complete sensor write
// - enable bits 2 and 1 are reserved
// - status flags set on event, clear on read
// - slot-4 control holds completion interrupt gate
`timescale 1ns/10ps
module sip_irq_core #(
    parameter int unsigned PULSE_CYC = sip_pkg::PULSE_CYC
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire sip_pkg::sip_wb_req_t wb_req_i,
    output sip_pkg::sip_wb_rsp_t      wb_rsp_o,
    input  wire sip_pkg::sip_aux_evt_t aux_evt_i,
    input  wire logic                 overflow_i,
    input  wire logic                 data_ready_i,
    input  wire logic                 frame_sync_pin_i,
    output logic                      irq_pin_o,
    output logic                      irq_pin_oe_o,
    output logic                      aux_bypass_o
);
    sip_pkg::sip_core_state_t s_reg;
    sip_pkg::sip_core_state_t s_next;

    // word index match
    function automatic logic hit(
        input logic [sip_pkg::ADR_W-1:0] adr,
        input logic [sip_pkg::IDX_W-1:0] idx
    );
        return adr[sip_pkg::ADR_W-1:2] == idx;
    endfunction

    // sticky flag update, set wins over clear
    function automatic logic [7:0] sticky(
        input logic [7:0] old,
        input logic [7:0] set,
        input logic       clr
    );
        return (old & ~{8{clr}}) | set;
    endfunction

    logic       acc;
    logic       rd;
    logic       wr;
    logic       fs_act;
    logic       fs_edge;
    logic       pass_ev;
    logic       mst_ev;
    logic [7:0] aux_set;
    logic [7:0] irq_set;
    logic       aux_clr;
    logic       irq_clr;
    logic       irq_req;
    logic       irq_active;

    // bus phases: read at take, write at ack edge
    assign acc = wb_req_i.cyc && wb_req_i.stb && !s_reg.ack;
    assign rd  = acc && !wb_req_i.we;
    assign wr  = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
                 && s_reg.ack && wb_req_i.sel[0];

    // frame-sync input, taken synchronous
    assign fs_act  = frame_sync_pin_i
                     ^ s_reg.pin_cfg[sip_pkg::B_FS_POL];
    assign fs_edge = fs_act && !s_reg.fs_q;
    assign pass_ev = fs_edge
                     && s_reg.pin_cfg[sip_pkg::B_FS_EN];

    // aux status events
    always_comb begin
        aux_set = '0;
        aux_set[sip_pkg::B_PASS]     = pass_ev;
        aux_set[sip_pkg::B_S4_DONE]  = aux_evt_i.slot4_done;
        aux_set[sip_pkg::B_ARB_LOST] = aux_evt_i.arb_lost;
        aux_set[sip_pkg::B_NACK_LO +: sip_pkg::NACK_N] = aux_evt_i.nack;
    end

    // combined aux interrupt event
    assign mst_ev = pass_ev
                    || (aux_evt_i.slot4_done && s_reg.s4_gate)
                    || aux_evt_i.arb_lost
                    || (|aux_evt_i.nack);

    always_comb begin
        irq_set = '0;
        irq_set[sip_pkg::B_OVF]  = overflow_i;
        irq_set[sip_pkg::B_MST]  = mst_ev;
        irq_set[sip_pkg::B_DRDY] = data_ready_i;
    end

    assign aux_clr = rd && hit(wb_req_i.adr, sip_pkg::IDX_AUX_STAT);
    assign irq_clr = rd && (hit(wb_req_i.adr, sip_pkg::IDX_IRQ_STAT)
                     || s_reg.pin_cfg[sip_pkg::B_ANY_RD_CLR]);

    // enabled pending flags request the pin
    assign irq_req = |(s_reg.irq_stat & s_reg.irq_en);

    always_comb begin
        s_next      = s_reg;
        s_next.ack  = acc;
        s_next.fs_q = fs_act;
        s_next.aux_stat = sticky(s_reg.aux_stat, aux_set, aux_clr);
        s_next.irq_stat = sticky(s_reg.irq_stat, irq_set, irq_clr);
        if (rd) begin
            if (hit(wb_req_i.adr, sip_pkg::IDX_AUX_STAT)) begin
                s_next.rdat = s_reg.aux_stat;
            end else if (hit(wb_req_i.adr, sip_pkg::IDX_PIN_CFG)) begin
                s_next.rdat = s_reg.pin_cfg;
            end else if (hit(wb_req_i.adr, sip_pkg::IDX_IRQ_EN)) begin
                s_next.rdat = s_reg.irq_en;
            end else if (hit(wb_req_i.adr, sip_pkg::IDX_IRQ_STAT)) begin
                s_next.rdat = s_reg.irq_stat;
            end else if (hit(wb_req_i.adr, sip_pkg::IDX_SLOT4_CTRL)) begin
                s_next.rdat = '0;
                s_next.rdat[sip_pkg::B_S4_GATE] = s_reg.s4_gate;
            end else if (hit(wb_req_i.adr, sip_pkg::IDX_USER_CTRL)) begin
                s_next.rdat = '0;
                s_next.rdat[sip_pkg::B_MST_ON] = s_reg.mst_on;
            end else begin
                s_next.rdat = '0;
            end
        end else if (acc) begin
            s_next.rdat = '0;
        end
        if (wr) begin
            if (hit(wb_req_i.adr, sip_pkg::IDX_PIN_CFG)) begin
                s_next.pin_cfg = wb_req_i.dat[7:0] & sip_pkg::PIN_CFG_MASK;
            end
            if (hit(wb_req_i.adr, sip_pkg::IDX_IRQ_EN)) begin
                s_next.irq_en = wb_req_i.dat[7:0]
                                & sip_pkg::IRQ_EN_MASK;
            end
            if (hit(wb_req_i.adr, sip_pkg::IDX_SLOT4_CTRL)) begin
                s_next.s4_gate = wb_req_i.dat[sip_pkg::B_S4_GATE];
            end
            if (hit(wb_req_i.adr, sip_pkg::IDX_USER_CTRL)) begin
                s_next.mst_on = wb_req_i.dat[sip_pkg::B_MST_ON];
            end
        end
        s_next.bypass = s_next.pin_cfg[sip_pkg::B_BYPASS]
                        && !s_next.mst_on;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // pin shaping
    sip_pin_drive #(
        .PULSE_CYC (PULSE_CYC)
    ) u_pin (
        .clk_i        (clk_i),
        .rst_b_i      (rst_b_i),
        .req_i        (irq_req),
        .act_low_i    (s_reg.pin_cfg[sip_pkg::B_ACT_LOW]),
        .open_drain_i (s_reg.pin_cfg[sip_pkg::B_OPEN_DRAIN]),
        .latch_i      (s_reg.pin_cfg[sip_pkg::B_LATCH]),
        .pin_o        (irq_pin_o),
        .pin_oe_o     (irq_pin_oe_o),
        .active_o     (irq_active)
    );

    assign wb_rsp_o.ack = s_reg.ack;
    assign wb_rsp_o.dat = {{(sip_pkg::DAT_W - 8){1'b0}}, s_reg.rdat};
    assign aux_bypass_o = s_reg.bypass;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_ack_single: assert property (
        wb_rsp_o.ack |=> !wb_rsp_o.ack
    ) else $error("ack held beyond one cycle");

    a_aux_rd_clear: assert property (
        aux_clr && aux_set == '0 |=> s_reg.aux_stat == '0
    ) else $error("aux status not cleared by read");

    a_pass_set: assert property (
        fs_edge && s_reg.pin_cfg[sip_pkg::B_FS_EN]
        |=> s_reg.aux_stat[sip_pkg::B_PASS] && s_reg.irq_stat[sip_pkg::B_MST]
    ) else $error("frame-sync event lost");

    a_pass_gate: assert property (
        !s_reg.pin_cfg[sip_pkg::B_FS_EN]
        |=> !$rose(s_reg.aux_stat[sip_pkg::B_PASS])
    ) else $error("pass-through set while disabled");

    a_s4_gate: assert property (
        aux_evt_i.slot4_done && !s_reg.s4_gate && !pass_ev
        && !aux_evt_i.arb_lost && aux_evt_i.nack == '0
        && !s_reg.irq_stat[sip_pkg::B_MST]
        |=> s_reg.aux_stat[sip_pkg::B_S4_DONE]
            && !s_reg.irq_stat[sip_pkg::B_MST]
    ) else $error("slot-4 done gate not applied");

    a_arb_set: assert property (
        aux_evt_i.arb_lost
        |=> s_reg.aux_stat[sip_pkg::B_ARB_LOST]
            && s_reg.irq_stat[sip_pkg::B_MST]
    ) else $error("arbitration loss not flagged");

    a_nack_set: assert property (
        aux_evt_i.nack != '0
        |=> (s_reg.aux_stat[sip_pkg::NACK_N-1:0] & $past(aux_evt_i.nack))
            == $past(aux_evt_i.nack)
    ) else $error("not-acknowledge flag missing");

    a_stat_clear: assert property (
        irq_clr && irq_set == '0 |=> s_reg.irq_stat == '0
    ) else $error("interrupt status not cleared");

    a_stat_keep: assert property (
        !irq_clr |=> ($past(s_reg.irq_stat) & ~s_reg.irq_stat) == '0
    ) else $error("interrupt status lost without read");

    a_drdy_set: assert property (
        data_ready_i |=> s_reg.irq_stat[sip_pkg::B_DRDY]
    ) else $error("data ready not flagged");

    a_en_reserved: assert property (
        s_reg.irq_en[2:1] == '0
    ) else $error("reserved enable bits stored");

    a_bypass_block: assert property (
        !s_reg.pin_cfg[sip_pkg::B_BYPASS] || s_reg.mst_on |-> !aux_bypass_o
    ) else $error("bypass open while blocked");

    a_irq_masked: assert property (
        s_reg.irq_en == '0 ##1 s_reg.irq_en == '0 [*2]
        |-> !irq_active || !s_reg.pin_cfg[sip_pkg::B_LATCH]
    ) else $error("latched pin active with all sources masked");

    a_irq_latch: assert property (
        irq_req && s_reg.pin_cfg[sip_pkg::B_LATCH]
        && $stable(s_reg.pin_cfg) ##1 irq_req && $stable(s_reg.pin_cfg)
        |=> irq_active
    ) else $error("pin not active with pending interrupt");

    a_ack_take: assert property (
        acc |=> wb_rsp_o.ack
    ) else $error("request taken without ack");

    a_rd_upper: assert property (
        wb_rsp_o.dat[sip_pkg::DAT_W-1:8] == '0
    ) else $error("read data upper bits not zero");

    a_aux_keep: assert property (
        !aux_clr |=> ($past(s_reg.aux_stat) & ~s_reg.aux_stat) == '0
    ) else $error("aux status lost without read");

    a_aux_rd_data: assert property (
        aux_clr |=> wb_rsp_o.dat[7:0] == $past(s_reg.aux_stat)
    ) else $error("aux status read returns wrong value");

    a_stat_rd_data: assert property (
        rd && hit(wb_req_i.adr, sip_pkg::IDX_IRQ_STAT)
        |=> wb_rsp_o.dat[7:0] == $past(s_reg.irq_stat)
    ) else $error("interrupt status read returns wrong value");

    a_wr_status: assert property (
        wr && hit(wb_req_i.adr, sip_pkg::IDX_AUX_STAT) && aux_set == '0
        |=> s_reg.aux_stat == $past(s_reg.aux_stat)
    ) else $error("aux status changed by a write");

    a_s4_flag: assert property (
        aux_evt_i.slot4_done |=> s_reg.aux_stat[sip_pkg::B_S4_DONE]
    ) else $error("slot-4 done flag missing");

    a_s4_irq: assert property (
        aux_evt_i.slot4_done && s_reg.s4_gate |=> s_reg.irq_stat[sip_pkg::B_MST]
    ) else $error("gated slot-4 done gives no aux interrupt");

    a_mst_nack: assert property (
        aux_evt_i.nack != '0 |=> s_reg.irq_stat[sip_pkg::B_MST]
    ) else $error("not-acknowledge gives no aux interrupt");

    a_ovf_set: assert property (
        overflow_i |=> s_reg.irq_stat[sip_pkg::B_OVF]
    ) else $error("overflow not flagged");

    a_stat_rsvd: assert property (
        (s_reg.irq_stat & ~sip_pkg::IRQ_EN_MASK) == '0
    ) else $error("reserved status bits set");

    a_cfg_rsvd: assert property (
        (s_reg.pin_cfg & ~sip_pkg::PIN_CFG_MASK) == '0
    ) else $error("reserved configuration bit stored");

    a_wr_cfg: assert property (
        wr && hit(wb_req_i.adr, sip_pkg::IDX_PIN_CFG)
        |=> s_reg.pin_cfg == ($past(wb_req_i.dat[7:0]) & sip_pkg::PIN_CFG_MASK)
    ) else $error("pin configuration write lost");

    a_fs_steady: assert property (
        $stable(frame_sync_pin_i) && $stable(s_reg.pin_cfg) |-> !pass_ev
    ) else $error("frame-sync event without a transition");

    a_bypass_open: assert property (
        s_reg.pin_cfg[sip_pkg::B_BYPASS] && !s_reg.mst_on |-> aux_bypass_o
    ) else $error("bypass closed while allowed");

    a_latch_drop: assert property (
        !irq_req && s_reg.pin_cfg[sip_pkg::B_LATCH] && $stable(s_reg.pin_cfg)
        |=> !irq_active
    ) else $error("latched pin still active after clear");

    c_rd_clear: cover property (aux_clr && s_reg.aux_stat != '0);
    c_any_rd: cover property (irq_clr && s_reg.pin_cfg[sip_pkg::B_ANY_RD_CLR]);
    c_pass: cover property (pass_ev && s_reg.irq_en[sip_pkg::B_MST]);
endmodule

// *** verification/sip_host_model.sv ***
// host side model: the interrupt line as the application processor sees it
`timescale 1ns/10ps
module sip_host_model (
    input  wire logic pin_i,
    input  wire logic oe_i,
    output logic      line_o
);
    // a released line floats up through the board pull-up
    assign line_o = oe_i ? pin_i : 1'b1;
endmodule

// *** verification/sip_irq_core_tb.sv ***
// self-checking bench of the sensor interrupt block
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module sip_irq_core_tb;
    localparam int unsigned PCYC = 8;
    localparam logic [6:0]  AUX  = sip_pkg::IDX_AUX_STAT;
    localparam logic [6:0]  STA  = sip_pkg::IDX_IRQ_STAT;
    localparam logic [6:0]  CFG  = sip_pkg::IDX_PIN_CFG;
    localparam logic [6:0]  EN   = sip_pkg::IDX_IRQ_EN;
    logic                   clk_i   = 1'b0;
    logic                   rst_b_i = 1'b0;
    sip_pkg::sip_wb_req_t   req     = '0;
    sip_pkg::sip_wb_rsp_t   rsp;
    sip_pkg::sip_aux_evt_t  aux     = '0;
    logic                   ovf     = 1'b0;
    logic                   drdy    = 1'b0;
    logic                   fs      = 1'b0;
    logic                   pin;
    logic                   oe;
    logic                   byp;
    logic                   line;
    logic [7:0]             q;
    int                     fails     = 0;
    int                     cmp_count = 0;

    always #4 clk_i = ~clk_i;

    sip_irq_core #(.PULSE_CYC(PCYC)) dut_u (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .wb_req_i(req), .wb_rsp_o(rsp),
        .aux_evt_i(aux), .overflow_i(ovf), .data_ready_i(drdy),
        .frame_sync_pin_i(fs), .irq_pin_o(pin), .irq_pin_oe_o(oe),
        .aux_bypass_o(byp)
    );
    sip_host_model host_u (.pin_i(pin), .oe_i(oe), .line_o(line));

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one classic cycle; read data lands in q
    task automatic wb(input logic w, input logic [6:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {ix, 2'b00}, sel: 4'hF, dat: {24'h0, d}};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 20);
        if (rsp.ack !== 1'b1) begin
            fails++;
            close_out();
        end
        q = rsp.dat[7:0];
        req <= '0;
        @(posedge clk_i);
    endtask

    task automatic rchk(input logic [6:0] ix, input logic [7:0] e);
        wb(1'b0, ix, 8'h00);
        `CHK(q, e)
    endtask

    task automatic setup(input logic [7:0] cfg, input logic [7:0] en);
        wb(1'b1, CFG, cfg);
        wb(1'b1, EN, en);
        wb(1'b0, AUX, 8'h00);
        wb(1'b0, STA, 8'h00);
    endtask

    // one-cycle event pulse, then time for flag and pin to follow
    task automatic evt(input logic [6:0] a, input logic o, input logic d);
        aux <= sip_pkg::sip_aux_evt_t'(a);
        ovf <= o;
        drdy <= d;
        @(posedge clk_i);
        aux <= '0;
        ovf <= 1'b0;
        drdy <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic t_regs();
        rchk(CFG, 8'h00);
        wb(1'b1, AUX, 8'hFF);
        rchk(AUX, 8'h00);
        wb(1'b1, EN, 8'hFF);
        rchk(EN, 8'h19);
        wb(1'b1, CFG, 8'hFF);
        rchk(CFG, 8'hFE);
        rchk(7'h10, 8'h00);
        $display("registers done");
    endtask

    task automatic t_aux();
        setup(8'h20, 8'h08);
        evt(7'h20, 1'b0, 1'b0);
        `CHK(line, 1'b1)
        rchk(AUX, 8'h20);
        rchk(AUX, 8'h00);
        rchk(STA, 8'h08);
        `CHK(line, 1'b0)
        for (int i = 0; i < 5; i++) begin
            evt(7'h01 << i, 1'b0, 1'b0);
            rchk(AUX, 8'h01 << i);
        end
        wb(1'b1, EN, 8'h00);
        evt(7'h20, 1'b1, 1'b0);
        `CHK(line, 1'b0)
        rchk(STA, 8'h18);
        $display("aux status done");
    endtask

    task automatic t_slot4();
        setup(8'h20, 8'h08);
        evt(7'h40, 1'b0, 1'b0);
        rchk(AUX, 8'h40);
        rchk(STA, 8'h00);
        wb(1'b1, sip_pkg::IDX_SLOT4_CTRL, 8'h40);
        evt(7'h40, 1'b0, 1'b0);
        `CHK(line, 1'b1)
        rchk(AUX, 8'h40);
        rchk(STA, 8'h08);
        $display("slot4 done");
    endtask

    task automatic t_frame_sync_pin();
        setup(8'h20, 8'h08);
        fs <= 1'b1;
        repeat (4) @(posedge clk_i);
        rchk(AUX, 8'h00);
        fs <= 1'b0;
        setup(8'h24, 8'h08);
        fs <= 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(line, 1'b1)
        rchk(AUX, 8'h80);
        setup(8'h2C, 8'h08);
        fs <= 1'b0;
        repeat (4) @(posedge clk_i);
        rchk(AUX, 8'h80);
        fs <= 1'b1;
        repeat (4) @(posedge clk_i);
        rchk(AUX, 8'h00);
        $display("frame sync done");
    endtask

    task automatic t_pin();
        setup(8'hE0, 8'h01);
        `CHK(oe, 1'b0)
        `CHK(line, 1'b1)
        evt(7'h00, 1'b0, 1'b1);
        `CHK(oe, 1'b1)
        `CHK(line, 1'b0)
        rchk(STA, 8'h01);
        @(posedge clk_i);
        `CHK(line, 1'b1)
        setup(8'hA0, 8'h01);
        `CHK(oe, 1'b1)
        `CHK(pin, 1'b1)
        $display("pin drive done");
    endtask

    task automatic t_pulse();
        int n;
        n = 0;
        setup(8'h00, 8'h01);
        drdy <= 1'b1;
        @(posedge clk_i);
        drdy <= 1'b0;
        repeat (24) begin
            @(posedge clk_i);
            if (line === 1'b1)
                n++;
        end
        `CHK(n, PCYC)
        rchk(STA, 8'h01);
        $display("pulse done");
    endtask

    task automatic t_anyrd();
        setup(8'h20, 8'h01);
        evt(7'h00, 1'b0, 1'b1);
        wb(1'b0, EN, 8'h00);
        rchk(STA, 8'h01);
        setup(8'h30, 8'h01);
        evt(7'h00, 1'b0, 1'b1);
        wb(1'b0, EN, 8'h00);
        rchk(STA, 8'h00);
        $display("read clear done");
    endtask

    task automatic t_bypass();
        wb(1'b1, CFG, 8'h02);
        `CHK(byp, 1'b1)
        wb(1'b1, sip_pkg::IDX_USER_CTRL, 8'h20);
        `CHK(byp, 1'b0)
        wb(1'b1, CFG, 8'h00);
        wb(1'b1, sip_pkg::IDX_USER_CTRL, 8'h00);
        `CHK(byp, 1'b0)
        $display("bypass done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        t_regs();
        t_aux();
        t_slot4();
        t_frame_sync_pin();
        t_pin();
        t_pulse();
        t_anyrd();
        t_bypass();
        close_out();
    end
endmodule
